//--- core/acc_event_detect.sv
/*
 * Synchroniser and edge detector for the comparator decision.
 * Assumes compRaw is asynchronous to core_clk; all else is local.
 */
`timescale 1ns/1ps
module acc_event_detect
   import acc_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clkEn,
   acc_evt_if.detect evt
);

   logic syncFirst_q, syncFirst_d;
   logic syncSecond_q, syncSecond_d;
   logic prev_q, prev_d;
   logic cur;

   // Match one sample pair against the selected event type
   function automatic logic matchEvent(input acc_evt_t sel, input logic c, input logic p);
      logic hit;
      hit = 1'b0;
      unique case (sel)
         EVT_TOGGLE: hit = (c != p);
         EVT_FALL:   hit = p & ~c;
         EVT_RISE:   hit = c & ~p;
         EVT_RSVD:   hit = 1'b0;
      endcase
      return hit;
   endfunction : matchEvent

   // Powered-down comparator reads low, gated after the second stage
   assign cur = syncSecond_q & ~evt.compOff;

   // Two-stage sync and previous sample
   always_comb begin
      syncFirst_d  = evt.compRaw;
      syncSecond_d = syncFirst_q;
      prev_d       = cur;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         syncFirst_q  <= 1'b0;
         syncSecond_q <= 1'b0;
         prev_q       <= 1'b0;
      end else if (clkEn) begin
         syncFirst_q  <= syncFirst_d;
         syncSecond_q <= syncSecond_d;
         prev_q       <= prev_d;
      end
   end

   assign evt.syncResult = cur;
   assign evt.eventHit   = matchEvent(evt.evtSel, cur, prev_q);

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   sync_latency_a: assert property (
      (clkEn && evt.compRaw && !evt.compOff) [*2] ##1 !evt.compOff |-> evt.syncResult)
      else $error("comparator result not through in two cycles");
   rsvd_mode_a: assert property (
      evt.evtSel == EVT_RSVD |-> !evt.eventHit)
      else $error("reserved mode raised an event");
   event_change_a: assert property (
      evt.eventHit |-> cur != prev_q)
      else $error("event without a sample change");

endmodule : acc_event_detect

//--- core/analog_comparator_control.sv
/*
 * Digital control and status around an analog comparator: input
 * selection, result sync, event flag, interrupt, capture routing,
 * hysteresis and digital-input-disable controls.
 * Assumes the analog macro returns its decision on compRaw
 * asynchronously, and that converter and CPU signals share core_clk.
 */
// Implementation choice: the strobed register port.
`timescale 1ns/1ps

// What this block does
// - Comparator result high while positive input exceeds negative input.
// - Result passes a two-stage sync before reading as status.
// - Event select: 00 toggle, 10 fall, 11 rise, 01 reserved.
// - Hardware sets the event flag on a matching output change.
// - Flag clears on interrupt vector or writing one; zero does nothing.
// - Interrupt requested only with flag, enable and global enable set.
// - Writing one to the off bit powers the comparator down.
// - Bandgap select picks internal reference, else positive pin.
// - Capture routing bit feeds result to the timer capture front end.
// - Negative input from converter channel only if mux on, converter off.
// - Hysteresis enable turns hysteresis on; level bit picks 20 or 50 mV.
// - Bit 4 of control register B always reads zero.
// - Pin input-disable bits turn off buffers and force pin reads zero.
module analog_comparator_control
   import acc_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              reset,
   input  wire logic              clkEn,
   // Register port
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [DATA_W-1:0] regWrData,
   input  wire logic              regWrStrobe,
   input  wire logic              regRdStrobe,
   output logic      [DATA_W-1:0] regRdData,
   // Analog comparator macro
   input  wire logic              compRaw,
   output logic                   compPowerOff,
   output logic                   posSelBandgap,
   output logic                   negSelMux,
   output logic      [3:0]        negChannel,
   output logic                   hystEnable,
   output logic                   hystLevel,
   // Converter and CPU context
   input  wire logic              converterEnable,
   input  wire logic [3:0]        converterChannel,
   input  wire logic              globalIrqEnable,
   input  wire logic              irqVectorAck,
   output logic                   compIrq,
   // Timer capture front end
   output logic                   captureTrigger,
   // Comparator pins, digital side
   input  wire logic [1:0]        pinLevelRaw,
   output logic      [1:0]        pinInputOff,
   output logic      [1:0]        pinLevelRead
);

   acc_evt_if evtBus ();

   logic [7:0] ctrlA_q, ctrlA_d;
   logic [7:0] ctrlB_q, ctrlB_d;
   logic [7:0] didr_q, didr_d;
   logic [7:0] rdData_q, rdData_d;
   logic       negMux_q, negMux_d;
   logic [3:0] negChan_q, negChan_d;
   logic       capTrig_q, capTrig_d;
   logic [1:0] pinSyncA_q, pinSyncA_d;
   logic [1:0] pinSyncB_q, pinSyncB_d;
   logic [1:0] pinRead_q, pinRead_d;
   logic       wrA, wrB, wrD;
   logic       flagSet, flagClr;
   logic [7:0] statusA;

   // Address decode, shared by the write path and the checks
   assign wrA = regWrStrobe && regAddr == OFFS_CTRL_A;
   assign wrB = regWrStrobe && regAddr == OFFS_CTRL_B;
   assign wrD = regWrStrobe && regAddr == OFFS_DIDR;

   // Detector hookup; the off bit also masks the decision
   assign evtBus.compRaw = compRaw;
   assign evtBus.compOff = ctrlA_q[A_OFF_BIT];
   assign evtBus.evtSel  = acc_evt_t'(ctrlA_q[A_SEL_LSB +: 2]);

   acc_event_detect u_detect (
      .core_clk (core_clk),
      .reset    (reset),
      .clkEn    (clkEn),
      .evt      (evtBus)
   );

   // Event flag: a set in the same cycle as a clear wins
   assign flagSet = evtBus.eventHit;
   assign flagClr = irqVectorAck || (wrA && regWrData[A_FLAG_BIT]);

   // Control and status register A
   always_comb begin
      ctrlA_d = ctrlA_q;
      if (wrA) begin
         ctrlA_d[A_OFF_BIT]           = regWrData[A_OFF_BIT];
         ctrlA_d[A_BG_BIT]            = regWrData[A_BG_BIT];
         ctrlA_d[A_IE_BIT]            = regWrData[A_IE_BIT];
         ctrlA_d[A_CAP_BIT]           = regWrData[A_CAP_BIT];
         ctrlA_d[A_SEL_LSB +: 2]      = regWrData[A_SEL_LSB +: 2];
      end
      ctrlA_d[A_RES_BIT] = 1'b0;       // Result is never stored here
      if (flagSet) begin
         ctrlA_d[A_FLAG_BIT] = 1'b1;
      end else if (flagClr) begin
         ctrlA_d[A_FLAG_BIT] = 1'b0;
      end
   end

   // Control register B; the reserved bit never stores
   always_comb begin
      ctrlB_d = ctrlB_q;
      if (wrB) begin
         ctrlB_d = regWrData & B_RW_MASK;
      end
   end

   // Digital input disable register
   always_comb begin
      didr_d = didr_q;
      if (wrD) begin
         didr_d = regWrData;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctrlA_q <= RST_CTRL_A;
         ctrlB_q <= RST_CTRL_B;
         didr_q  <= RST_DIDR;
      end else if (clkEn) begin
         ctrlA_q <= ctrlA_d;
         ctrlB_q <= ctrlB_d;
         didr_q  <= didr_d;
      end
   end

   // Live view of register A with the synchronized result
   always_comb begin
      statusA            = ctrlA_q;
      statusA[A_RES_BIT] = evtBus.syncResult;
   end

   // Read data stands for exactly one cycle; unmapped reads give zero
   always_comb begin
      rdData_d = '0;
      if (regRdStrobe) begin
         unique case (regAddr)
            OFFS_CTRL_A: rdData_d = statusA;
            OFFS_CTRL_B: rdData_d = ctrlB_q;
            OFFS_DIDR:   rdData_d = didr_q;
            default:     rdData_d = '0;
         endcase
      end
   end

   // Negative input route, registered so the analog mux sees clean levels
   always_comb begin
      negMux_d  = ctrlB_q[B_MUX_BIT] && !converterEnable;
      negChan_d = negMux_d ? converterChannel : 4'h0;
   end

   // Capture routing: no connection while the bit is clear
   always_comb begin
      capTrig_d = ctrlA_q[A_CAP_BIT] && evtBus.syncResult;
   end

   // Pin levels are asynchronous: two stages, then the disable gate
   always_comb begin
      pinSyncA_d = pinLevelRaw;
      pinSyncB_d = pinSyncA_q;
      pinRead_d  = pinSyncB_q & ~pinInputOff;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         rdData_q   <= '0;
         negMux_q   <= 1'b0;
         negChan_q  <= 4'h0;
         capTrig_q  <= 1'b0;
         pinSyncA_q <= 2'b00;
         pinSyncB_q <= 2'b00;
         pinRead_q  <= 2'b00;
      end else if (clkEn) begin
         rdData_q   <= rdData_d;
         negMux_q   <= negMux_d;
         negChan_q  <= negChan_d;
         capTrig_q  <= capTrig_d;
         pinSyncA_q <= pinSyncA_d;
         pinSyncB_q <= pinSyncB_d;
         pinRead_q  <= pinRead_d;
      end
   end

   // Outputs to the analog macro and neighbours
   assign regRdData      = rdData_q;
   assign compPowerOff   = ctrlA_q[A_OFF_BIT];
   assign posSelBandgap  = ctrlA_q[A_BG_BIT];
   assign negSelMux      = negMux_q;
   assign negChannel     = negChan_q;
   assign hystEnable     = ctrlB_q[B_HYST_BIT];
   assign hystLevel      = ctrlB_q[B_HYST_BIT] & ctrlB_q[B_HYSTERESIS_LEVEL_BIT];
   assign captureTrigger = capTrig_q;
   assign pinInputOff    = {didr_q[D_NEG_BIT], didr_q[D_POS_BIT]};
   assign pinLevelRead   = pinRead_q;

   // Level interrupt; software must drop the enable before mode changes
   assign compIrq = ctrlA_q[A_FLAG_BIT] && ctrlA_q[A_IE_BIT]
                    && globalIrqEnable;

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   flag_set_a: assert property (
      clkEn && flagSet |=> ctrlA_q[A_FLAG_BIT])
      else $error("event did not set the flag");
   flag_clear_a: assert property (
      clkEn && wrA && regWrData[A_FLAG_BIT] && !flagSet |=> !ctrlA_q[A_FLAG_BIT])
      else $error("write one did not clear the flag");
   flag_hold_a: assert property (
      clkEn && ctrlA_q[A_FLAG_BIT] && !irqVectorAck && !(wrA && regWrData[A_FLAG_BIT])
      |=> ctrlA_q[A_FLAG_BIT])
      else $error("flag lost without a clear");
   irq_gate_a: assert property (
      compIrq |-> ctrlA_q[A_FLAG_BIT] && ctrlA_q[A_IE_BIT] && globalIrqEnable)
      else $error("interrupt without flag and enables");
   power_off_a: assert property (
      clkEn && wrA |=> compPowerOff == $past(regWrData[A_OFF_BIT]))
      else $error("off bit write not applied");
   bandgap_sel_a: assert property (
      clkEn && wrA |=> posSelBandgap == $past(regWrData[A_BG_BIT]))
      else $error("bandgap select not applied");
   capture_gate_a: assert property (
      clkEn && !ctrlA_q[A_CAP_BIT] |=> !captureTrigger)
      else $error("capture driven while routing off");
   neg_mux_a: assert property (
      clkEn && converterEnable |=> !negSelMux)
      else $error("mux used with converter on");
   hyst_level_a: assert property (
      hystLevel |-> hystEnable)
      else $error("hysteresis level without enable");
   rsvd_read_a: assert property (
      clkEn && regRdStrobe && regAddr == OFFS_CTRL_B |=> !regRdData[B_RSVD_BIT])
      else $error("reserved bit read as one");
   pin_off_a: assert property (
      clkEn && didr_q[D_POS_BIT] && !wrD |=> !pinLevelRead[0])
      else $error("disabled pin read as one");
   rd_pulse_a: assert property (
      clkEn && !regRdStrobe |=> regRdData == 8'h00)
      else $error("read data outside the read cycle");

   // Output behaviour, incl. corners the bench seldom reaches
   flag_race_a: assert property (
      clkEn && flagSet && flagClr |=> ctrlA_q[A_FLAG_BIT])
      else $error("clear beat a same-cycle event");
   flag_vector_a: assert property (
      clkEn && irqVectorAck && !flagSet |=> !ctrlA_q[A_FLAG_BIT])
      else $error("vector did not clear the flag");
   irq_enable_a: assert property (
      clkEn && wrA && !regWrData[A_IE_BIT] |=> !compIrq)
      else $error("interrupt with enable cleared");
   status_read_a: assert property (
      clkEn && regRdStrobe && regAddr == OFFS_CTRL_A
      |=> regRdData[A_RES_BIT] == $past(evtBus.syncResult))
      else $error("status read lost the result");
   capture_follow_a: assert property (
      clkEn && ctrlA_q[A_CAP_BIT] |=> captureTrigger == $past(evtBus.syncResult))
      else $error("capture not following the result");
   neg_route_a: assert property (
      clkEn && ctrlB_q[B_MUX_BIT] && !converterEnable
      |=> negSelMux && negChannel == $past(converterChannel))
      else $error("converter channel not routed");
   neg_idle_a: assert property (
      clkEn && !ctrlB_q[B_MUX_BIT] |=> !negSelMux && negChannel == 4'h0)
      else $error("mux routed while disabled");
   hyst_write_a: assert property (
      clkEn && wrB |=> hystEnable == $past(regWrData[B_HYST_BIT]))
      else $error("hysteresis enable not applied");
   pin_neg_off_a: assert property (
      clkEn && didr_q[D_NEG_BIT] |=> !pinLevelRead[1])
      else $error("disabled negative pin read as one");
   didr_write_a: assert property (
      clkEn && wrD
      |=> pinInputOff == {$past(regWrData[D_NEG_BIT]), $past(regWrData[D_POS_BIT])})
      else $error("input disable write not applied");
   freeze_a: assert property (
      !clkEn |=> $stable(ctrlA_q) && $stable(regRdData))
      else $error("state moved with clock enable low");

   flag_cov: cover property (clkEn && flagSet ##1 compIrq);
   clear_cov: cover property (ctrlA_q[A_FLAG_BIT] && irqVectorAck);
   race_cov: cover property (clkEn && flagSet && flagClr);
   mux_cov: cover property (negSelMux ##1 !negSelMux);

endmodule : analog_comparator_control

//--- include/acc_evt_if.sv
/*
 * Carrier between the control top and the event detector.
 * Assumes both ends share core_clk.
 */
`timescale 1ns/1ps
interface acc_evt_if;
   import acc_pkg::*;
   logic     compRaw;
   logic     compOff;
   acc_evt_t evtSel;
   logic     syncResult;
   logic     eventHit;

   modport detect (
      input  compRaw,
      input  compOff,
      input  evtSel,
      output syncResult,
      output eventHit
   );
   modport ctrl (
      output compRaw,
      output compOff,
      output evtSel,
      input  syncResult,
      input  eventHit
   );
endinterface : acc_evt_if

//--- include/acc_pkg.sv
/*
 * Shared constants and types for the comparator control block:
 * register offsets, field positions, reset values, event encodings.
 * Assumes an 8-bit register port with 8-bit addresses.
 */
package acc_pkg;

   // Register port geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // Register offsets
   localparam logic [7:0] OFFS_CTRL_B = 8'h05;
   localparam logic [7:0] OFFS_CTRL_A = 8'h06;
   localparam logic [7:0] OFFS_DIDR   = 8'h60;

   // comparator_control_status_a fields
   localparam int unsigned A_OFF_BIT  = 7;
   localparam int unsigned A_BG_BIT   = 6;
   localparam int unsigned A_RES_BIT  = 5;
   localparam int unsigned A_FLAG_BIT = 4;
   localparam int unsigned A_IE_BIT   = 3;
   localparam int unsigned A_CAP_BIT  = 2;
   localparam int unsigned A_SEL_LSB  = 0;

   // comparator_control_b fields
   localparam int unsigned B_HYST_BIT = 7;
   localparam int unsigned B_HYSTERESIS_LEVEL_BIT = 6;
   localparam int unsigned B_RSVD_BIT = 4;
   localparam int unsigned B_MUX_BIT  = 2;
   localparam logic [7:0]  B_RW_MASK  = 8'hEF;

   // digital_input_disable_0 fields
   localparam int unsigned D_POS_BIT = 1;
   localparam int unsigned D_NEG_BIT = 2;

   // Reset values
   localparam logic [7:0] RST_CTRL_A = 8'h00;
   localparam logic [7:0] RST_CTRL_B = 8'h00;
   localparam logic [7:0] RST_DIDR   = 8'h00;

   // Output event selection
   typedef enum logic [1:0] {
      EVT_TOGGLE = 2'b00,
      EVT_RSVD   = 2'b01,
      EVT_FALL   = 2'b10,
      EVT_RISE   = 2'b11
   } acc_evt_t;

endpackage : acc_pkg

//--- testbench/acc_analog_src.sv
/*
 * Analog sources on the comparator pins, with the comparator decision.
 * Assumes the bench sets the pin voltage codes.
 */
`timescale 1ns/1ps
module acc_analog_src
   import acc_pkg::*;
#(
   parameter logic [7:0] BG_LEVEL = 8'h60
)
(
   input  wire logic       posSelBandgap,
   input  wire logic       negSelMux,
   input  wire logic [3:0] negChannel,
   input  wire logic [7:0] posVolt,
   input  wire logic [7:0] negVolt,
   output logic            compRaw,
   output logic      [1:0] pinLevelRaw
);
   logic [7:0] posIn;
   logic [7:0] negIn;
   // Channel n sits at 16*n so the bench can predict it
   assign posIn = posSelBandgap ? BG_LEVEL : posVolt;
   assign negIn = negSelMux ? {negChannel, 4'h0} : negVolt;
   assign compRaw = posIn > negIn;
   // Digital threshold at mid-rail
   assign pinLevelRaw = {negVolt[7], posVolt[7]};
endmodule : acc_analog_src

//--- testbench/analog_comparator_control_tb.sv
/*
 * Self-checking bench for the comparator control block.
 * Assumes a 20 MHz core clock and the analog source model.
 */
`timescale 1ns/1ps
module analog_comparator_control_tb
   import acc_pkg::*;
;
   logic       core_clk = 1'b0, reset = 1'b1, clkEn = 1'b1;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
   logic       regWrStrobe = 1'b0, regRdStrobe = 1'b0;
   logic [7:0] posVolt = 8'h10, negVolt = 8'h40;
   logic [3:0] converterChannel = 4'h5, negChannel;
   logic       converterEnable = 1'b0, globalIrqEnable = 1'b0, irqVectorAck = 1'b0;
   logic       compRaw, compPowerOff, posSelBandgap, negSelMux, hystEnable, hystLevel;
   logic       compIrq, captureTrigger;
   logic [1:0] pinLevelRaw, pinInputOff, pinLevelRead;
   int         failures = 0, comparisons = 0, cycles = 0;
   acc_evt_t   modes[4] = '{EVT_TOGGLE, EVT_FALL, EVT_RISE, EVT_RSVD};

   analog_comparator_control u_analog_comparator_control (
      .core_clk(core_clk), .reset(reset), .clkEn(clkEn), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
      .regRdData(regRdData), .compRaw(compRaw), .compPowerOff(compPowerOff),
      .posSelBandgap(posSelBandgap), .negSelMux(negSelMux), .negChannel(negChannel),
      .hystEnable(hystEnable), .hystLevel(hystLevel), .converterEnable(converterEnable),
      .converterChannel(converterChannel), .globalIrqEnable(globalIrqEnable),
      .irqVectorAck(irqVectorAck), .compIrq(compIrq), .captureTrigger(captureTrigger),
      .pinLevelRaw(pinLevelRaw), .pinInputOff(pinInputOff), .pinLevelRead(pinLevelRead));

   acc_analog_src u_acc_analog_src (
      .posSelBandgap(posSelBandgap), .negSelMux(negSelMux), .negChannel(negChannel),
      .posVolt(posVolt), .negVolt(negVolt), .compRaw(compRaw), .pinLevelRaw(pinLevelRaw));

   // 50 ns period
   always #25 core_clk = ~core_clk;

   // Hang guard, far above the expected run of about 570 cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 8000) begin
         failures++;
         final_report();
      end
   end

   task automatic final_report;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask : cmp

   // Strobe released one edge later; idle cycle avoids double assignment
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrStrobe <= 1'b1;
      @(posedge core_clk);
      regWrStrobe <= 1'b0;
      @(posedge core_clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      regAddr <= a;
      regRdStrobe <= 1'b1;
      @(posedge core_clk);
      regRdStrobe <= 1'b0;
      @(negedge core_clk);
      d = regRdData;
      @(posedge core_clk);
   endtask : rd

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string msg);
      logic [7:0] d;
      rd(a, d);
      cmp(d, exp, msg);
   endtask : rdc

   // Sync plus edge detect plus margin
   task automatic settle;
      repeat (4) @(posedge core_clk);
   endtask : settle

   function automatic logic [7:0] expA(logic [7:0] w, logic res, logic flg);
      return {w[7:6], res, flg, w[3:0]};
   endfunction : expA

   function automatic logic expRes(logic [7:0] p, logic [7:0] n, logic bg, logic mx,
                                   logic [3:0] ch);
      return (bg ? 8'h60 : p) > (mx ? {ch, 4'h0} : n);
   endfunction : expRes

   initial begin
      logic [7:0] b, dd, d;
      logic [1:0] m;
      void'($urandom(32'h1776));
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      rdc(OFFS_CTRL_A, RST_CTRL_A, "ctrl A reset");
      rdc(OFFS_CTRL_B, RST_CTRL_B, "ctrl B reset");
      rdc(OFFS_DIDR, RST_DIDR, "disable reset");
      wr(8'h07, 8'hFF);
      rdc(8'h07, 8'h00, "unmapped");
      wr(OFFS_CTRL_B, 8'hD4);
      rdc(OFFS_CTRL_B, 8'hC4, "ctrl B bit4");
      cmp({negSelMux, negChannel, hystEnable, hystLevel}, 8'h57, "mux hyst");
      converterEnable <= 1'b1;
      settle();
      cmp(negSelMux, 1'b0, "mux with converter on");
      converterEnable <= 1'b0;
      wr(OFFS_CTRL_B, 8'h40);
      cmp({hystEnable, hystLevel}, 2'b00, "hyst off");
      wr(OFFS_CTRL_B, 8'h80);
      cmp({hystEnable, hystLevel}, 2'b10, "hyst 20mV");
      // A write while the clock enable is low must be lost
      clkEn <= 1'b0;
      wr(OFFS_CTRL_B, 8'h00);
      clkEn <= 1'b1;
      rdc(OFFS_CTRL_B, 8'h80, "frozen write");
      $display("test registers done");
      // Each event mode against a rise then a fall
      foreach (modes[i]) begin
         m = modes[i];
         wr(OFFS_CTRL_A, {6'h00, m});
         wr(OFFS_CTRL_A, {6'h01, m} | 8'h10);
         rdc(OFFS_CTRL_A, {6'h01, m}, "flag cleared");
         posVolt <= 8'hC0;
         settle();
         rdc(OFFS_CTRL_A, expA({6'h01, m}, 1'b1, m == 2'b00 || m == 2'b11), "rise");
         wr(OFFS_CTRL_A, {6'h01, m} | 8'h10);
         rdc(OFFS_CTRL_A, expA({6'h01, m}, 1'b1, 1'b0), "steady high");
         posVolt <= 8'h10;
         settle();
         rdc(OFFS_CTRL_A, expA({6'h01, m}, 1'b0, m == 2'b00 || m == 2'b10), "fall");
      end
      $display("test event modes done");
      wr(OFFS_CTRL_A, 8'h1B);
      posVolt <= 8'hC0;
      settle();
      @(negedge core_clk);
      cmp(compIrq, 1'b0, "irq without global");
      @(posedge core_clk);
      globalIrqEnable <= 1'b1;
      @(negedge core_clk);
      cmp(compIrq, 1'b1, "irq raised");
      @(posedge core_clk);
      wr(OFFS_CTRL_A, 8'h0B);
      @(negedge core_clk);
      cmp(compIrq, 1'b1, "write zero keeps flag");
      @(posedge core_clk);
      irqVectorAck <= 1'b1;
      @(posedge core_clk);
      irqVectorAck <= 1'b0;
      @(negedge core_clk);
      cmp(compIrq, 1'b0, "vector clears");
      @(posedge core_clk);
      wr(OFFS_CTRL_A, 8'h13);
      posVolt <= 8'h10;
      settle();
      posVolt <= 8'hC0;
      settle();
      @(negedge core_clk);
      cmp(compIrq, 1'b0, "irq masked");
      @(posedge core_clk);
      wr(OFFS_CTRL_A, 8'h0B);
      @(negedge core_clk);
      cmp(compIrq, 1'b1, "irq unmasked");
      @(posedge core_clk);
      wr(OFFS_CTRL_A, 8'h13);
      globalIrqEnable <= 1'b0;
      $display("test interrupt done");
      wr(OFFS_CTRL_A, 8'h04);
      settle();
      cmp(captureTrigger, 1'b1, "capture on");
      wr(OFFS_CTRL_A, 8'h00);
      settle();
      cmp(captureTrigger, 1'b0, "capture off");
      wr(OFFS_CTRL_A, 8'h80);
      settle();
      cmp(compPowerOff, 1'b1, "power off");
      rdc(OFFS_CTRL_A, expA(8'h80, 1'b0, 1'b1), "off forces low");
      posVolt <= 8'h00;
      wr(OFFS_CTRL_A, 8'h50);
      settle();
      cmp({compPowerOff, posSelBandgap}, 2'b01, "bandgap");
      rdc(OFFS_CTRL_A, expA(8'h40, 1'b1, 1'b1), "bandgap result");
      $display("test capture power bandgap done");
      // Random voltages, channel, mux and input disables
      repeat (24) begin
         b = $urandom & 8'hD4;
         dd = $urandom;
         posVolt <= $urandom;
         negVolt <= $urandom;
         converterChannel <= $urandom;
         converterEnable <= $urandom;
         // Converter power reduction is taken as cleared before the mux is used
         wr(OFFS_CTRL_B, b);
         wr(OFFS_DIDR, dd);
         wr(OFFS_CTRL_A, {1'b0, dd[0], 6'h10});
         settle();
         rd(OFFS_CTRL_A, d);
         cmp(d[5], expRes(posVolt, negVolt, dd[0], b[2] & ~converterEnable,
                          converterChannel), "result");
         cmp(negChannel, (b[2] & ~converterEnable) ? converterChannel : 4'h0, "chan");
         rdc(OFFS_CTRL_B, b & B_RW_MASK, "ctrl B");
         rdc(OFFS_DIDR, dd, "disable reg");
         cmp({pinInputOff, pinLevelRead}, {dd[2:1], ~dd[2] & negVolt[7],
                                          ~dd[1] & posVolt[7]}, "pins");
         cmp({hystEnable, hystLevel}, {b[7], b[7] & b[6]}, "hyst");
      end
      $display("test random done");
      final_report();
   end
endmodule : analog_comparator_control_tb
